// ---- rtl/drp_bank_timer.sv ----
`timescale 1ns/1ps
`include "drp_defines.svh"
module drp_bank_timer
  import drp_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire drp_req_t req,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic [3:0] bank_open,
  output logic [3:0] bank_precharging,
  output logic [3:0] rl_event
);
  localparam int NB = `DRP_NUM_BANKS;
  localparam int CW = `DRP_CNT_W;

  // Configuration: [2:0] additive_latency, [6:4] cas_latency, [8] burst of eight
  logic [31:0] cfg;
  logic [CW-1:0] ras_cnt [NB];
  logic [CW-1:0] rtp_cnt [NB];
  logic [CW-1:0] ap_cnt [NB];
  logic [CW-1:0] rp_cnt [NB];
  logic [NB-1:0] ap_pend;
  logic [NB-1:0] open_q;
  logic [NB-1:0] prech_q;
  logic [15:0] ap_done_cnt;
  logic [CW-1:0] rl_cnt;
  logic [1:0] rl_bank;
  logic ack;

  wire logic [2:0] additive_latency = cfg[2:0];
  wire logic [2:0] cas_latency = cfg[6:4];
  wire logic bl8 = cfg[8];
  wire logic [CW-1:0] half_bl = bl8 ? CW'(4) : CW'(2);
  wire logic [CW-1:0] read_latency = CW'(additive_latency) + CW'(cas_latency);
  // Last prefetch edge is AL, or AL+2 for burst of eight
  wire logic [CW-1:0] prefetch_ofs = CW'(additive_latency) + (bl8 ? CW'(2) : CW'(0));
  wire logic is_rd = req.cmd == DRP_CMD_RD;
  wire logic is_act = req.cmd == DRP_CMD_ACT;
  wire logic is_pre = req.cmd == DRP_CMD_PRE;
  wire logic ap_sel = req.addr[`DRP_AP_BIT];
  wire logic bus_acc = (avs_read | avs_write) & ~ack;
  wire logic [31:0] rd_mux =
    (avs_address == `DRP_REG_CFG) ? cfg :
    (avs_address == `DRP_REG_STAT) ? {16'h0000, 4'h0, ap_pend, prech_q, open_q} :
    (avs_address == `DRP_REG_CNT) ? {16'h0000, ap_done_cnt} : 32'h0000_0000;

  function automatic logic [CW-1:0] dec(input logic [CW-1:0] v);
    dec = (v == '0) ? v : v - CW'(1);
  endfunction : dec

  // A counter loaded with N at edge L reads 1 just before edge L+N,
  // so a minimum of N clocks is met at that edge, not one edge later
  function automatic logic due(input logic [CW-1:0] v);
    due = v <= CW'(1);
  endfunction : due

  // Single-wait-state slave; unmapped reads return zero
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      ack <= 1'b0;
      avs_readdata <= 32'h0000_0000;
      cfg <= `DRP_CFG_RST;
    end
    else
    begin
      ack <= bus_acc;
      if (bus_acc && avs_read)
        avs_readdata <= rd_mux;
      if (bus_acc && avs_write && avs_address == `DRP_REG_CFG)
      begin
        for (int b = 0; b < 4; b++)
          if (avs_byteenable[b])
            cfg[8*b +: 8] <= avs_writedata[8*b +: 8];
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      avs_waitrequest <= 1'b1;
    else
      avs_waitrequest <= ~bus_acc;
  end

  // Per-bank timers; commands to any bank are taken every cycle
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      open_q <= '0;
      prech_q <= '0;
      ap_pend <= '0;
      ap_done_cnt <= 16'h0000;
      for (int b = 0; b < NB; b++)
      begin
        ras_cnt[b] <= '0;
        rtp_cnt[b] <= '0;
        ap_cnt[b] <= '0;
        rp_cnt[b] <= '0;
      end
    end
    else
    begin
      for (int b = 0; b < NB; b++)
      begin
        ras_cnt[b] <= dec(ras_cnt[b]);
        rtp_cnt[b] <= dec(rtp_cnt[b]);
        ap_cnt[b] <= dec(ap_cnt[b]);
        rp_cnt[b] <= dec(rp_cnt[b]);
        if (prech_q[b] && rp_cnt[b] <= CW'(1))
          prech_q[b] <= 1'b0;
        // Start only when nominal edge, row_active_min_time and read_to_precharge_time all met
        if (ap_pend[b] && due(ap_cnt[b]) && due(ras_cnt[b]) && due(rtp_cnt[b]))
        begin
          ap_pend[b] <= 1'b0;
          open_q[b] <= 1'b0;
          prech_q[b] <= 1'b1;
          // Counted from the actual start, not a later edge
          rp_cnt[b] <= CW'(`DRP_TRP_CYC);
          ap_done_cnt <= ap_done_cnt + 16'h0001;
        end
        if (req.bank == 2'(b))
        begin
          if (is_act && !prech_q[b])
          begin
            open_q[b] <= 1'b1;
            ras_cnt[b] <= CW'(`DRP_ROW_ACTIVE_MIN_TIME_CYC);
          end
          if (is_rd && open_q[b])
          begin
            // read_to_precharge_time from last prefetch, never under two clocks
            rtp_cnt[b] <= prefetch_ofs + ((`DRP_READ_TO_PRECHARGE_TIME_CYC > 2) ? CW'(`DRP_READ_TO_PRECHARGE_TIME_CYC) : CW'(2));
            if (ap_sel)
            begin
              ap_pend[b] <= 1'b1;
              ap_cnt[b] <= CW'(additive_latency) + half_bl;
            end
          end
          // Explicit precharge honoured on an open bank unless an auto-precharge is pending; spacing is the controller's duty
          if (is_pre && open_q[b] && !ap_pend[b])
          begin
            open_q[b] <= 1'b0;
            prech_q[b] <= 1'b1;
            rp_cnt[b] <= CW'(`DRP_TRP_CYC);
          end
        end
      end
    end
  end

  // First read data element marker after read_latency
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      rl_cnt <= '0;
      rl_bank <= 2'b00;
      rl_event <= 4'h0;
    end
    else
    begin
      rl_event <= 4'h0;
      if (rl_cnt != '0)
      begin
        rl_cnt <= rl_cnt - CW'(1);
        if (rl_cnt == CW'(1))
          rl_event[rl_bank] <= 1'b1;
      end
      if (is_rd)
      begin
        rl_cnt <= (read_latency == '0) ? CW'(1) : read_latency;
        rl_bank <= req.bank;
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      bank_open <= 4'h0;
      bank_precharging <= 4'h0;
    end
    else
    begin
      bank_open <= open_q;
      bank_precharging <= prech_q;
    end
  end
endmodule : drp_bank_timer

// ---- rtl/drp_defines.svh ----
`ifndef DRP_DEFINES_SVH
`define DRP_DEFINES_SVH
// Clock period and timing figures (ps); counts are derived, minimums round up
`define DRP_TCK_PS 8000
`define DRP_READ_TO_PRECHARGE_TIME_PS 7500
`define DRP_TRP_PS 15000
`define DRP_ROW_ACTIVE_MIN_TIME_PS 40000
`define DRP_CEIL(ps) (((ps) + `DRP_TCK_PS - 1) / `DRP_TCK_PS)
`define DRP_READ_TO_PRECHARGE_TIME_CYC `DRP_CEIL(`DRP_READ_TO_PRECHARGE_TIME_PS)
`define DRP_TRP_CYC `DRP_CEIL(`DRP_TRP_PS)
`define DRP_ROW_ACTIVE_MIN_TIME_CYC `DRP_CEIL(`DRP_ROW_ACTIVE_MIN_TIME_PS)
`define DRP_NUM_BANKS 4
`define DRP_BANK_W 2
`define DRP_CNT_W 6
`define DRP_AP_BIT 10
`define DRP_ADDR_W 14
// Register map, Avalon word addresses
`define DRP_REG_CFG 4'h0
`define DRP_REG_STAT 4'h1
`define DRP_REG_CNT 4'h2
`define DRP_CFG_RST 32'h0000_0020
`endif

// ---- rtl/drp_pkg.sv ----
package drp_pkg;
  typedef enum logic [2:0] {
    DRP_CMD_NOP,
    DRP_CMD_ACT,
    DRP_CMD_RD,
    DRP_CMD_WR,
    DRP_CMD_PRE
  } drp_cmd_t;
  typedef struct packed {
    drp_cmd_t cmd;
    logic [1:0] bank;
    logic [13:0] addr;
  } drp_req_t;
  typedef enum logic [1:0] {
    DRP_IDLE,
    DRP_OPEN,
    DRP_AP_WAIT,
    DRP_PRECH
  } drp_bank_st_t;
endpackage : drp_pkg

// ---- tb/drp_bank_timer_bench.sv ----
`timescale 1ns/1ps
module drp_bank_timer_bench;
  import drp_pkg::*;
  logic clk = 0, rst_n = 0, go = 0, ap = 0, busy, avs_read = 0, avs_write = 0, avs_waitrequest;
  logic [1:0] bank = 0;
  logic [3:0] avs_address = 0, be = 4'hF, bank_open, bank_precharging, rl_event;
  logic [31:0] avs_readdata, avs_writedata = 0, rd, v;
  drp_req_t req;
  int errors = 0, compares = 0, seed = 50953, aps = 0, rls = 0, n;
  always #4 clk = ~clk;
  always @(posedge clk) if (rst_n) rls <= rls + $countones(rl_event);
  drp_ctrl_model ctl (.clk(clk), .rst_n(rst_n), .go(go), .bank(bank), .ap(ap), .req(req),
    .busy(busy));
  drp_bank_timer dut (.clk(clk), .rst_n(rst_n), .req(req), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(be), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .bank_open(bank_open), .bank_precharging(bank_precharging), .rl_event(rl_event));
  function logic [31:0] exp_cnt(input int k);
    return {16'h0000, 16'(k)};
  endfunction : exp_cnt
  task test_done;
    $display("errors %0d compares %0d", errors, compares);
    if (errors == 0 && compares > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : test_done
  task check(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  // Release comes one edge after the answer so the next request never collides
  task bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    avs_write <= w;
    avs_read <= !w;
    avs_address <= a;
    avs_writedata <= d;
    n = 0;
    do @(posedge clk); while (avs_waitrequest !== 1'b0 && ++n < 20);
    if (n >= 20)
    begin
      errors++;
      test_done;
    end
    rd = avs_readdata;
    avs_read <= 0;
    avs_write <= 0;
    @(posedge clk);
  endtask : bus
  initial
  begin
    repeat (12) @(posedge clk);
    rst_n <= 1;
    @(posedge clk);
    bus(1, 4'h0, 32'h0000_0020);
    bus(0, 4'h0, 0);
    check(rd, 32'h0000_0020);
    bus(0, 4'hF, 0);
    check(rd, 0);
    for (int i = 0; i < 24; i++)
    begin
      if (i == 12)
        bus(1, 4'h0, 32'h0000_0120);
      v = $random(seed);
      bank <= i < 2 ? 2'h0 : v[1:0];
      ap <= i < 2 ? i == 0 : v[2];
      aps += i < 2 ? int'(i == 0) : int'(v[2]);
      go <= 1;
      @(posedge clk);
      go <= 0;
      n = 0;
      do @(posedge clk); while (busy !== 1'b0 && ++n < 40);
      if (n >= 40)
      begin
        errors++;
        test_done;
      end
      bus(0, 4'h1, 0);
      check(rd, 0);
    end
    bus(0, 4'h2, 0);
    check(rd, exp_cnt(aps));
    check(rls, 24);
    bus(0, 4'h0, 0);
    check(rd, 32'h0000_0120);
    test_done;
  end
endmodule : drp_bank_timer_bench

// ---- tb/drp_bank_timer_properties.sv ----
`timescale 1ns/1ps
module drp_checker
  import drp_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire drp_req_t req,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic avs_waitrequest,
  input wire logic [3:0] bank_open,
  input wire logic [3:0] bank_precharging,
  input wire logic [3:0] rl_event
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  wire logic p0 = bank_precharging[0];
  sequence rd0;
    req.cmd == DRP_CMD_RD && req.bank == 2'h0;
  endsequence
  sequence rd_ap0;
    rd0 ##0 req.addr[10];
  endsequence
  ap_engage_a: assert property (rd_ap0 |-> ##[1:12] $rose(p0)) else $error("no precharge");
  ap_early_a: assert property (rd_ap0 |=> !p0 [*2]) else $error("early");
  ras_hold_a: assert property ($rose(bank_open[0]) |-> !p0 [*4]) else $error("ras");
  rp_len_a: assert property ($rose(p0) |=> p0 ##[1:2] !p0) else $error("rp length");
  rl_time_a: assert property (rd0 |-> ##[3:4] rl_event[0]) else $error("latency");
  rl_solo_a: assert property ($onehot0(rl_event)) else $error("two banks");
  other_bank_a: assert property (req.cmd == DRP_CMD_ACT && req.bank == 2'h1 && !bank_precharging[1]
    |-> ##[1:2] bank_open[1]) else $error("bank refused");
  bus_ack_a: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("no ack");
endmodule : drp_checker
bind drp_bank_timer drp_checker chk (.*);

// ---- tb/drp_ctrl_model.sv ----
`timescale 1ns/1ps
module drp_ctrl_model
  import drp_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic go,
  input wire logic [1:0] bank,
  input wire logic ap,
  output drp_req_t req,
  output logic busy
);
  logic [4:0] cnt;
  wire logic [1:0] nb = bank + 2'h1;
  // Fixed slots, rounded up to whole clocks, keep every spacing legal
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      req <= '0;
      busy <= 1'b0;
      cnt <= 5'h00;
    end
    else if (busy)
    begin
      cnt <= cnt + 5'h01;
      busy <= cnt != 5'h11;
      case (cnt)
        5'h01: req <= '{DRP_CMD_ACT, bank, 14'h0000};
        5'h03: req <= '{DRP_CMD_RD, bank, {3'h0, ap, 10'h000}};
        5'h07: req <= '{DRP_CMD_ACT, nb, 14'h0000};
        5'h09: req <= ap ? drp_req_t'('0) : drp_req_t'{DRP_CMD_PRE, bank, 14'h0000};
        5'h0D: req <= '{DRP_CMD_PRE, nb, 14'h0000};
        default: req <= '0;
      endcase
    end
    else
    begin
      req <= '0;
      if (go)
      begin
        busy <= 1'b1;
        cnt <= 5'h00;
      end
    end
  end
endmodule : drp_ctrl_model
